// ---- rtl/cfg_pkg.sv ----
package cfg_pkg;
    // ****************************************************
    // Serial control frame and device register map
    // ****************************************************
    localparam int FRAME_BITS = 16;
    localparam int CMD_BITS = 8;
    localparam int READ_FLAG_BIT = 15;
    localparam logic [6:0] REG_GLOBAL = 7'h00;
    localparam logic [6:0] REG_STATUS = 7'h01;
    localparam int GLB_ENABLE_BIT = 7;
    localparam int GLB_HPF_BIT = 4;
    localparam int GLB_FMT_LSB = 2;
    localparam int GLB_ROLE_LSB = 0;
    localparam logic [7:0] GLB_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [1:0] FMT_LEFT_JUST = 2'h0;
    localparam logic [1:0] FMT_I2S = 2'h1;
    localparam logic [1:0] FMT_TDM = 2'h2;
    localparam logic [1:0] FMT_RESERVED = 2'h3;
    localparam logic [1:0] ROLE_SLAVE_AUTO = 2'h3;
    localparam logic CLK_SRC_EXT_RESET = 1'h1;

    // ****************************************************
    // Timing, all at the 100 ns system clock
    // ****************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int I2C_RST_TO_START_NS = 600;
    localparam int SPI_RST_TO_CS_NS = 20;
    localparam int SPI_CS_SETUP_NS = 20;
    localparam int SPI_CS_HIGH_NS = 1000;
    localparam int SPI_CCLK_PHASE_NS = 66;
    localparam int I2C_RST_CYC = (I2C_RST_TO_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPI_RST_CYC = (SPI_RST_TO_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_WAIT_CYC = (I2C_RST_CYC > SPI_RST_CYC) ? I2C_RST_CYC : SPI_RST_CYC;
    localparam int CS_SETUP_CYC = (SPI_CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_HIGH_CYC = (SPI_CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CCLK_PHASE_CYC = (SPI_CCLK_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CCLK_HALF_DEFAULT = 4;

    // ****************************************************
    // Controller registers on AXI4-Lite
    // ****************************************************
    localparam logic [11:0] OFS_CMD = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_RDATA = 12'h008;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_READY_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/cfg_link_if.sv ----
`timescale 1ns/100ps
interface cfg_link_if;
    logic cs_n;
    logic cclk;
    logic cdin;
    logic cdout_o;
    logic cdout_oe;
    logic cdout;

    // Pulled high when nobody drives the shared data-out pin
    assign cdout = cdout_oe ? cdout_o : 1'b1;

    modport dev (
        input cs_n,
        input cclk,
        input cdin,
        output cdout_o,
        output cdout_oe
    );

    modport host (
        output cs_n,
        output cclk,
        output cdin,
        input cdout
    );
endinterface

// ---- rtl/sync2.sv ----
`timescale 1ns/100ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_q;

    if (W < 1)
    begin : g_chk
        $error("sync2 width must be at least one");
    end

    always_comb
    begin
        nxt_meta = en_i ? d_i : meta_ff;
        nxt_q = en_i ? meta_ff : q_ff;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;
endmodule

// ---- rtl/cfg_device.sv ----
`timescale 1ns/100ps
module cfg_device (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    cfg_link_if.dev LINK,
    input wire logic ROLE_SPEED_SELECT_HI_I,
    input wire logic ROLE_SPEED_SELECT_LO_I,
    input wire logic AUDIO_FORMAT_SELECT_HI_I,
    input wire logic AUDIO_FORMAT_SELECT_LO_I,
    input wire logic CLK_SRC_EXT_I,
    input wire logic CRYSTAL_INPUT_I,
    output logic CRYSTAL_DRIVE_OUTPUT_O,
    input wire logic MCLK_I,
    output logic MCLK_O,
    output logic MCLK_OE_O,
    output logic MASTER_CLK_O,
    output logic REG_CONTROL_O,
    output logic [1:0] ROLE_SPEED_O,
    output logic [1:0] AUDIO_FORMAT_O,
    output logic FORMAT_RESERVED_O,
    output logic SLAVE_MODE_O,
    output logic HPF_BYPASS_O
);
    import cfg_pkg::*;

    // ****************************************************
    // Link domain: serial shifter on the control clock
    // ****************************************************
    logic link_rst_n;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic [14:0] shift_ff;
    logic [14:0] nxt_shift;
    logic [7:0] out_ff;
    logic [7:0] nxt_out;
    logic [7:0] global_ff;
    logic [7:0] nxt_global;
    logic tgl_ff;
    logic nxt_tgl;
    logic cmd_rd;
    logic [6:0] cmd_addr;
    logic [7:0] rd_val;
    logic [7:0] stat_core;
    logic [7:0] stat_link;

    // Chip select high clears the frame; the clock stops between frames
    assign link_rst_n = RST_N_I & ~LINK.cs_n;
    assign cmd_rd = shift_ff[CMD_BITS-2];
    assign cmd_addr = {shift_ff[CMD_BITS-3:0], LINK.cdin};

    // Status is quasi-static and only sampled by reads
    sync2 #(
        .W(8)
    ) u_stat_sync (
        .clk_i(LINK.cclk),
        .rst_n_i(RST_N_I),
        .en_i(1'b1),
        .d_i(stat_core),
        .q_o(stat_link)
    );

    always_comb
    begin
        if (cmd_addr == REG_GLOBAL)
        begin
            rd_val = global_ff;
        end
        else if (cmd_addr == REG_STATUS)
        begin
            rd_val = stat_link;
        end
        else
        begin
            rd_val = UNMAPPED_READ;
        end
    end

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_shift = {shift_ff[13:0], LINK.cdin};
        nxt_out = {out_ff[6:0], 1'b0};
        nxt_global = global_ff;
        nxt_tgl = tgl_ff;
        if (cnt_ff != 5'(FRAME_BITS))
        begin
            nxt_cnt = cnt_ff + 5'h01;
        end
        if (cnt_ff == 5'(CMD_BITS - 1) && cmd_rd)
        begin
            nxt_out = rd_val;
        end
        if (cnt_ff == 5'(FRAME_BITS - 1) && !shift_ff[READ_FLAG_BIT-1]
            && shift_ff[13:7] == REG_GLOBAL)
        begin
            nxt_global = {shift_ff[6:0], LINK.cdin};
            nxt_tgl = ~tgl_ff;
        end
    end

    always_ff @(posedge LINK.cclk or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            cnt_ff <= 5'h00;
            shift_ff <= 15'h0000;
            out_ff <= 8'h00;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            out_ff <= nxt_out;
        end
    end

    // Survives chip select; only reset clears it
    always_ff @(posedge LINK.cclk or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            global_ff <= GLB_RESET;
            tgl_ff <= 1'b0;
        end
        else
        begin
            global_ff <= nxt_global;
            tgl_ff <= nxt_tgl;
        end
    end

    // Data-out pin is driven only inside a selected frame
    assign LINK.cdout_o = out_ff[7];
    assign LINK.cdout_oe = ~LINK.cs_n;

    // ****************************************************
    // Core domain: mode selection
    // ****************************************************
    logic [4:0] pins_sync;
    logic tgl_sync;
    logic seen_ff;
    logic nxt_seen;
    logic [7:0] ctrl_ff;
    logic [7:0] nxt_ctrl;
    logic [1:0] strap_done_ff;
    logic [1:0] nxt_strap_done;
    logic src_ext_ff;
    logic nxt_src_ext;
    logic [6:0] mode_ff;
    logic [6:0] nxt_mode;
    logic control_port_enable;

    sync2 #(
        .W(5)
    ) u_pin_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .en_i(CE_I),
        .d_i({CLK_SRC_EXT_I, ROLE_SPEED_SELECT_HI_I, ROLE_SPEED_SELECT_LO_I,
              AUDIO_FORMAT_SELECT_HI_I, AUDIO_FORMAT_SELECT_LO_I}),
        .q_o(pins_sync)
    );

    sync2 #(
        .W(1)
    ) u_tgl_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .en_i(CE_I),
        .d_i(tgl_ff),
        .q_o(tgl_sync)
    );

    assign control_port_enable = ctrl_ff[GLB_ENABLE_BIT];

    // mode_ff: {reg_ctl, hpf, fmt_rsvd, fmt[1:0], role[1:0]}
    always_comb
    begin
        nxt_seen = tgl_sync;
        nxt_ctrl = ctrl_ff;
        nxt_strap_done = strap_done_ff + 2'(~&strap_done_ff);
        nxt_src_ext = src_ext_ff;
        // Written word is stable in the link domain once the toggle lands
        if (tgl_sync != seen_ff)
        begin
            nxt_ctrl = global_ff;
        end
        // Strap caught after the pin synchroniser has filled
        if (strap_done_ff == 2'h2)
        begin
            nxt_src_ext = pins_sync[4];
        end
        if (control_port_enable)
        begin
            nxt_mode[6] = 1'b1;
            nxt_mode[5] = ctrl_ff[GLB_HPF_BIT];
            nxt_mode[3:2] = ctrl_ff[GLB_FMT_LSB+:2];
            nxt_mode[1:0] = ctrl_ff[GLB_ROLE_LSB+:2];
        end
        else
        begin
            // Stand-alone keeps the filter on: the bypass is register-only
            nxt_mode[6] = 1'b0;
            nxt_mode[5] = 1'b0;
            nxt_mode[3:2] = pins_sync[1:0];
            nxt_mode[1:0] = pins_sync[3:2];
        end
        nxt_mode[4] = (nxt_mode[3:2] == FMT_RESERVED);
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            seen_ff <= 1'b0;
            ctrl_ff <= GLB_RESET;
            strap_done_ff <= 2'h0;
            src_ext_ff <= CLK_SRC_EXT_RESET;
            mode_ff <= 7'h00;
        end
        else if (CE_I)
        begin
            seen_ff <= nxt_seen;
            ctrl_ff <= nxt_ctrl;
            strap_done_ff <= nxt_strap_done;
            src_ext_ff <= nxt_src_ext;
            mode_ff <= nxt_mode;
        end
    end

    assign stat_core = {control_port_enable, src_ext_ff, mode_ff[5:0]};

    // ****************************************************
    // Master clock routing
    // ****************************************************
    // Pin stays undriven until the strap is known, avoiding a fight
    assign MASTER_CLK_O = src_ext_ff ? MCLK_I : CRYSTAL_INPUT_I;
    assign MCLK_O = CRYSTAL_INPUT_I;
    assign MCLK_OE_O = ~src_ext_ff;
    assign CRYSTAL_DRIVE_OUTPUT_O = src_ext_ff ? 1'b0 : ~CRYSTAL_INPUT_I;

    assign REG_CONTROL_O = mode_ff[6];
    assign HPF_BYPASS_O = mode_ff[5];
    assign FORMAT_RESERVED_O = mode_ff[4];
    assign AUDIO_FORMAT_O = mode_ff[3:2];
    assign ROLE_SPEED_O = mode_ff[1:0];
    assign SLAVE_MODE_O = (mode_ff[1:0] == ROLE_SLAVE_AUTO);
endmodule

// ---- rtl/cfg_host.sv ----
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module cfg_host #(
    parameter int HALF_CYC = cfg_pkg::CCLK_HALF_DEFAULT
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    cfg_link_if.host LINK,
    input wire logic [11:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [11:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I
);
    import cfg_pkg::*;

    typedef enum logic [2:0] {ST_RST_WAIT, ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} state_t;

    if (HALF_CYC < CCLK_PHASE_CYC || HALF_CYC < CS_SETUP_CYC || HALF_CYC < 2
        || HALF_CYC > 255)
    begin : g_chk
        $error("HALF_CYC outside 2..255 or below the clock phase minimum");
    end

    // ****************************************************
    // AXI4-Lite slave
    // ****************************************************
    logic aw_ff, w_ff, bv_ff, rv_ff, strb_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic start;
    state_t st_ff, nxt_st;
    logic [7:0] rx_ff;
    logic [7:0] last_ff;

    assign AWREADY_O = ~aw_ff & ~bv_ff;
    assign WREADY_O = ~w_ff & ~bv_ff;
    assign ARREADY_O = ~rv_ff;
    // Commands need both low lanes and an idle port
    assign start = aw_ff && w_ff && !bv_ff && awaddr_ff == OFS_CMD && st_ff == ST_IDLE
        && strb_ff;

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            strb_ff <= 1'b0;
            bv_ff <= 1'b0;
            rv_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            rdata_ff <= 32'h0000_0000;
            bresp_ff <= RESP_OKAY;
            rresp_ff <= RESP_OKAY;
        end
        else if (CE_I)
        begin
            if (AWVALID_I && AWREADY_O)
            begin
                aw_ff <= 1'b1;
                awaddr_ff <= AWADDR_I;
            end
            if (WVALID_I && WREADY_O)
            begin
                w_ff <= 1'b1;
                wdata_ff <= WDATA_I;
                strb_ff <= WSTRB_I[1:0] == 2'h3;
            end
            if (aw_ff && w_ff && !bv_ff)
            begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                bv_ff <= 1'b1;
                bresp_ff <= (awaddr_ff == OFS_CMD) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bv_ff && BREADY_I)
            begin
                bv_ff <= 1'b0;
            end
            if (ARVALID_I && ARREADY_O)
            begin
                rv_ff <= 1'b1;
                rresp_ff <= RESP_OKAY;
                if (ARADDR_I == OFS_STATUS)
                begin
                    rdata_ff <= {30'h0000_0000, st_ff != ST_RST_WAIT, st_ff != ST_IDLE};
                end
                else if (ARADDR_I == OFS_RDATA)
                begin
                    rdata_ff <= {24'h00_0000, last_ff};
                end
                else if (ARADDR_I == OFS_CMD)
                begin
                    rdata_ff <= wdata_ff;
                end
                else
                begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= RESP_SLVERR;
                end
            end
            else if (rv_ff && RREADY_I)
            begin
                rv_ff <= 1'b0;
            end
        end
    end

    assign BVALID_O = bv_ff;
    assign BRESP_O = bresp_ff;
    assign RVALID_O = rv_ff;
    assign RDATA_O = rdata_ff;
    assign RRESP_O = rresp_ff;

    // ****************************************************
    // Serial port master, clock divided from CLK_I
    // ****************************************************
    logic [7:0] tmr_ff, nxt_tmr;
    logic [3:0] bit_ff, nxt_bit;
    logic [15:0] tx_ff, nxt_tx;
    logic [7:0] nxt_rx, nxt_last;
    logic cs_n_ff, nxt_cs_n, cclk_ff, nxt_cclk;
    logic cdout_sync;

    sync2 #(
        .W(1)
    ) u_cdout_sync (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .en_i(CE_I),
        .d_i(LINK.cdout),
        .q_o(cdout_sync)
    );

    always_comb
    begin
        nxt_st = st_ff;
        nxt_tmr = tmr_ff + 8'h01;
        nxt_bit = bit_ff;
        nxt_tx = tx_ff;
        nxt_rx = rx_ff;
        nxt_last = last_ff;
        nxt_cs_n = cs_n_ff;
        nxt_cclk = cclk_ff;
        case (st_ff)
            ST_RST_WAIT:
                if (tmr_ff == 8'(RST_WAIT_CYC - 1))
                begin
                    nxt_st = ST_IDLE;
                end
            ST_IDLE:
            begin
                nxt_tmr = 8'h00;
                if (start)
                begin
                    nxt_tx = wdata_ff[15:0];
                    nxt_bit = 4'h0;
                    nxt_cs_n = 1'b0;
                    nxt_st = ST_LOW;
                end
            end
            ST_LOW:
                if (tmr_ff == 8'(HALF_CYC - 1))
                begin
                    nxt_tmr = 8'h00;
                    nxt_cclk = 1'b1;
                    if (bit_ff >= 4'(CMD_BITS))
                    begin
                        nxt_rx = {rx_ff[6:0], cdout_sync};
                    end
                    nxt_st = ST_HIGH;
                end
            ST_HIGH:
                if (tmr_ff == 8'(HALF_CYC - 1))
                begin
                    nxt_tmr = 8'h00;
                    nxt_cclk = 1'b0;
                    if (bit_ff == 4'(FRAME_BITS - 1))
                    begin
                        nxt_cs_n = 1'b1;
                        nxt_last = rx_ff;
                        nxt_st = ST_GAP;
                    end
                    else
                    begin
                        nxt_bit = bit_ff + 4'h1;
                        nxt_tx = {tx_ff[14:0], 1'b0};
                        nxt_st = ST_LOW;
                    end
                end
            ST_GAP:
                if (tmr_ff == 8'(CS_HIGH_CYC - 1))
                begin
                    nxt_st = ST_IDLE;
                end
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            st_ff <= ST_RST_WAIT;
            tmr_ff <= 8'h00;
            bit_ff <= 4'h0;
            tx_ff <= 16'h0000;
            rx_ff <= 8'h00;
            last_ff <= 8'h00;
            cs_n_ff <= 1'b1;
            cclk_ff <= 1'b0;
        end
        else if (CE_I)
        begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            bit_ff <= nxt_bit;
            tx_ff <= nxt_tx;
            rx_ff <= nxt_rx;
            last_ff <= nxt_last;
            cs_n_ff <= nxt_cs_n;
            cclk_ff <= nxt_cclk;
        end
    end

    assign LINK.cs_n = cs_n_ff;
    assign LINK.cclk = cclk_ff;
    assign LINK.cdin = tx_ff[15];
endmodule

// ---- verif/cfg_link_monitor.sv ----
`timescale 1ns/100ps
module cfg_link_monitor #(
    parameter int HALF_CYC = 4
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic cs_n,
    input wire logic cclk,
    input wire logic cdin,
    input wire logic cdout_o,
    input wire logic cdout_oe,
    input wire logic cdout
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // ****************************************************
    // Helper counters
    // ****************************************************
    logic [3:0] rst_ff;
    logic [3:0] hi_ff;
    logic [7:0] run_ff;
    logic [4:0] rise_ff;

    // Gap counter starts full so the first frame is judged by rst_ff alone
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rst_ff <= 4'h0;
            hi_ff <= 4'hf;
            run_ff <= 8'h00;
            rise_ff <= 5'h00;
        end
        else
        begin
            rst_ff <= (rst_ff == 4'hf) ? rst_ff : rst_ff + 4'h1;
            hi_ff <= $rose(cs_n) ? 4'h0 : ((hi_ff == 4'hf) ? hi_ff : hi_ff + 4'h1);
            run_ff <= ($changed(cclk) || $changed(cs_n)) ? 8'h00 : run_ff + 8'h01;
            rise_ff <= $fell(cs_n) ? 5'h00 : rise_ff + {4'h0, $rose(cclk)};
        end
    end

    // ****************************************************
    // Link framing
    // ****************************************************
    sequence lead_in_s;
        !cclk [*4] ##1 cclk;
    endsequence

    sequence frame_end_s;
        ##128 $rose(cs_n);
    endsequence

    a_first_edge: assert property ($fell(cs_n) |-> lead_in_s)
        else $error("first link clock edge not one half period after select");
    a_frame_length: assert property ($fell(cs_n) |-> frame_end_s)
        else $error("frame length wrong");
    a_half_period: assert property ($changed(cclk) |-> run_ff == HALF_CYC - 1)
        else $error("link clock half period wrong");
    a_sixteen_rises: assert property ($rose(cs_n) |-> rise_ff == 5'h10)
        else $error("frame without sixteen rising edges");
    a_cs_gap: assert property ($fell(cs_n) |-> hi_ff >= 4'h9)
        else $error("select high time too short");
    a_reset_wait: assert property ($fell(cs_n) |-> rst_ff >= 4'h6)
        else $error("select fell too soon after reset");
    a_cdin_steady: assert property (!cs_n && $changed(cdin) |-> $fell(cclk) || $fell(cs_n))
        else $error("data in changed away from falling edge");
    a_idle_quiet: assert property (cs_n |-> !cclk)
        else $error("link clock runs outside a frame");
    a_out_released: assert property (cs_n |-> !cdout_oe && cdout)
        else $error("data out driven while deselected");
endmodule

// ---- verif/config_source_select_tb.sv ----
`timescale 1ns/100ps
module config_source_select_tb;
    import cfg_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, src_ext = 1'b0, xtal = 1'b0, mclk_in = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, xdrv, mclk_o, mclk_oe, master_clk;
    logic reg_ctl, rsvd, slave, hpf;
    logic [1:0] bresp, rresp, role, fmt, r;
    logic [31:0] rdata, d;
    logic [7:0] glob, v;
    logic [7:0] exp_q[$];
    int seed = 32'he025_9bd9;
    int mismatches = 0, checked = 0, i;

    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        xtal <= ~xtal;
        mclk_in <= mclk_in ^ xtal;
    end

    cfg_link_if cfg_link_if_i ();
    cfg_device cfg_device_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .LINK(cfg_link_if_i.dev), .ROLE_SPEED_SELECT_HI_I(pins[1]),
        .ROLE_SPEED_SELECT_LO_I(pins[0]), .AUDIO_FORMAT_SELECT_HI_I(pins[3]),
        .AUDIO_FORMAT_SELECT_LO_I(pins[2]), .CLK_SRC_EXT_I(src_ext), .CRYSTAL_INPUT_I(xtal),
        .CRYSTAL_DRIVE_OUTPUT_O(xdrv), .MCLK_I(mclk_in), .MCLK_O(mclk_o), .MCLK_OE_O(mclk_oe),
        .MASTER_CLK_O(master_clk), .REG_CONTROL_O(reg_ctl), .ROLE_SPEED_O(role),
        .AUDIO_FORMAT_O(fmt), .FORMAT_RESERVED_O(rsvd), .SLAVE_MODE_O(slave),
        .HPF_BYPASS_O(hpf));
    cfg_host #(.HALF_CYC(4)) cfg_host_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
        .LINK(cfg_link_if_i.host), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
        .RREADY_I(rready));
    cfg_link_monitor #(.HALF_CYC(4)) cfg_link_monitor_i (.CLK_I(clk), .RST_N_I(rst_n),
        .cs_n(cfg_link_if_i.cs_n), .cclk(cfg_link_if_i.cclk), .cdin(cfg_link_if_i.cdin),
        .cdout_o(cfg_link_if_i.cdout_o), .cdout_oe(cfg_link_if_i.cdout_oe),
        .cdout(cfg_link_if_i.cdout));

    // ****************************************************
    // Reference model and checking
    // ****************************************************
    function automatic logic [7:0] exp_mode(input logic [7:0] g, input logic [3:0] p);
        logic [3:0] m;
        m = g[7] ? g[3:0] : p;
        return {g[7], g[7] & g[4], m[1:0] == 2'h3, m[3:2] == 2'h3, m};
    endfunction

    task automatic wrap_up();
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pin and register changes need a few core edges to land
    task automatic chk_mode();
        repeat (8) @(posedge clk);
        @(negedge clk);
        check({24'h0, reg_ctl, hpf, slave, rsvd, fmt, role}, {24'h0, exp_mode(glob, pins)});
    endtask

    task automatic clk_chk(input logic ext);
        repeat (4)
        begin
            @(negedge clk);
            check({29'h0, mclk_oe, xdrv, master_clk}, {29'h0, ~ext, ~ext & ~xtal, ext ? mclk_in : xtal});
            if (!ext)
                check({31'h0, mclk_o}, {31'h0, xtal});
        end
    endtask

    // ****************************************************
    // Bus tasks
    // ****************************************************
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] dt, input logic [3:0] s);
        int n;
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= dt;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100 && !b_t; n++)
        begin
            @(negedge clk);
            aw_t = awvalid & awready;
            w_t = wvalid & wready;
            b_t = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end
        if (!b_t)
        begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic axi_rd(input logic [11:0] a);
        int n;
        logic a_t, t;
        t = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100 && !t; n++)
        begin
            @(negedge clk);
            a_t = arvalid & arready;
            t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (a_t) arvalid <= 1'b0;
            if (t) rready <= 1'b0;
        end
        if (!t)
        begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic wait_stat(input int b, input logic val);
        int n;
        for (n = 0; n < 300; n++)
        begin
            axi_rd(OFS_STATUS);
            if (d[b] === val) break;
        end
        if (n == 300)
        begin
            mismatches++;
            wrap_up();
        end
    endtask

    task automatic link(input logic [15:0] f);
        axi_wr(OFS_CMD, {16'h0000, f}, 4'hf);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        wait_stat(STAT_BUSY_BIT, 1'b0);
        if (!f[15] && f[14:8] == REG_GLOBAL) glob = f[7:0];
        if (f[15])
        begin
            axi_rd(OFS_RDATA);
            check({24'h0, d[7:0]}, {24'h0, exp_q.pop_front()});
        end
    endtask

    task automatic do_reset(input logic ext);
        @(posedge clk);
        rst_n <= 1'b0;
        src_ext <= ext;
        glob = GLB_RESET;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        wait_stat(STAT_READY_BIT, 1'b1);
    endtask

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        do_reset(1'b0);
        clk_chk(1'b0);
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk);
            pins <= i[3:0];
            chk_mode();
        end
        axi_wr(12'h00c, 32'h0000_00ff, 4'hf);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(OFS_STATUS, 32'h0000_00ff, 4'hf);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_rd(12'h010);
        check({d[29:0], r}, {30'h0, RESP_SLVERR});
        for (i = 0; i < 4; i++)
        begin
            v = {1'b1, 2'h0, 1'($random(seed)), i[1:0], 2'(3 - i)};
            link({1'b0, REG_GLOBAL, v});
            @(posedge clk);
            pins <= 4'($random(seed));
            chk_mode();
            exp_q.push_back(v);
            link({1'b1, REG_GLOBAL, 8'h00});
            exp_q.push_back({glob[7], src_ext, glob[4], glob[3:2] == 2'h3, glob[3:0]});
            link({1'b1, REG_STATUS, 8'h00});
        end
        exp_q.push_back(UNMAPPED_READ);
        link({1'b1, 7'h55, 8'h00});
        // Narrow strobe and busy overlap are both ignored
        axi_wr(OFS_CMD, {16'h0000, 1'b0, REG_GLOBAL, 8'h81}, 4'h1);
        axi_wr(OFS_CMD, {16'h0000, 1'b0, REG_GLOBAL, 8'h86}, 4'hf);
        axi_wr(OFS_CMD, {16'h0000, 1'b0, REG_GLOBAL, 8'h8b}, 4'hf);
        glob = 8'h86;
        wait_stat(STAT_BUSY_BIT, 1'b0);
        chk_mode();
        do_reset(1'b1);
        chk_mode();
        clk_chk(1'b1);
        wrap_up();
    end
endmodule
